// ### eqc_defines.svh
// Offsets, field positions and reset values of the channel config bank
// Functional notes
// - Eight channel bytes at indexes 3..10, ordered A0..A3 then B0..B3.
// - Bits 7..4 of a channel byte are its equalizer code, bit 7 MSB.
// - Bits 3..2 of a channel byte are its flat-gain code, bit 3 upper.
// - Bit 0 selects output swing; bit 1 is stored but drives nothing.
// - All bits of bytes 3..11 read and write, and reset to zero.
// - Byte 11 bits 7..4 power down A3..A0 detectors, bits 3..0 B3..B0.
// - Flat-gain code 00/01/10/11 means -4/-2/0/+2 dB.
// - Swing select 0 means 900 mVpp, 1 means 1000 mVpp.
`ifndef EQC_DEFINES_SVH
`define EQC_DEFINES_SVH

// ==========================================================================
// Byte indexes
`define EQC_CHAN_FIRST_IDX 8'h03
`define EQC_CHAN_LAST_IDX  8'h0A
`define EQC_PD_IDX         8'h0B
`define EQC_IDX_MAX        8'hFF

// ==========================================================================
// Register offsets by name
`define EQC_CHAN_A0_CONFIG_IDX              8'h03
`define EQC_CHAN_A1_CONFIG_IDX              8'h04
`define EQC_CHAN_A2_CONFIG_IDX              8'h05
`define EQC_CHAN_A3_CONFIG_IDX              8'h06
`define EQC_CHAN_B0_CONFIG_IDX              8'h07
`define EQC_CHAN_B1_CONFIG_IDX              8'h08
`define EQC_CHAN_B2_CONFIG_IDX              8'h09
`define EQC_CHAN_B3_CONFIG_IDX              8'h0A
`define EQC_ACTIVITY_DETECTOR_POWERDOWN_IDX 8'h0B

// ==========================================================================
// Channel byte fields
`define EQC_EQ_MSB   7
`define EQC_EQ_LSB   4
`define EQC_FG_MSB   3
`define EQC_FG_LSB   2
`define EQC_RSVD_BIT 1
`define EQC_SW_BIT   0

// ==========================================================================
// Detector power-down byte layout and reset values
`define EQC_PD_GRP_A_LSB 4
`define EQC_CFG_RESET    8'h00
`define EQC_PD_RESET     8'h00
`define EQC_RD_UNMAPPED  8'h00

`endif

// ### eqc_pkg.sv
// Types shared by the channel config bank
`default_nettype none

package eqc_pkg;

    // ======================================================================
    // Access state, one-hot
    typedef enum logic [1:0] {
        EQC_ACC_IDLE = 2'b01,
        EQC_ACC_OPEN = 2'b10
    } eqc_acc_state_t;

    // ======================================================================
    // Analog settings selected by the fields
    typedef enum logic [1:0] {
        EQC_FG_M4DB = 2'b00,
        EQC_FG_M2DB = 2'b01,
        EQC_FG_0DB  = 2'b10,
        EQC_FG_P2DB = 2'b11
    } eqc_flat_gain_t;

    typedef enum logic {
        EQC_SW_900MV  = 1'b0,
        EQC_SW_1000MV = 1'b1
    } eqc_swing_t;

endpackage : eqc_pkg

`default_nettype wire

// ### eqc_cfg_byte.sv
// One channel configuration byte with its field outputs
`timescale 1ns/1ps
`default_nettype none
`include "eqc_defines.svh"

module eqc_cfg_byte
    import eqc_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wr_data_i,
    output logic      [7:0] byte_o,
    output logic      [3:0] eq_code_o,
    output logic      [1:0] flat_gain_o,
    output logic            swing_o
);

    logic [7:0] byte_reg;
    logic [7:0] byte_next;

    // ======================================================================
    // Storage; bit 1 is kept only so that it reads back
    always_comb begin
        byte_next = byte_reg;
        if (wr_en_i) begin
            byte_next = wr_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            byte_reg <= `EQC_CFG_RESET;
        end else begin
            byte_reg <= byte_next;
        end
    end

    assign byte_o      = byte_reg;
    assign eq_code_o   = byte_reg[`EQC_EQ_MSB:`EQC_EQ_LSB];
    assign flat_gain_o = byte_reg[`EQC_FG_MSB:`EQC_FG_LSB];
    assign swing_o     = byte_reg[`EQC_SW_BIT];

    // ======================================================================
    // Checks
    byte_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !wr_en_i |=> byte_o == $past(byte_o))
        else $error("config byte changed without a write");

endmodule : eqc_cfg_byte

`default_nettype wire

// ### eqc_config_regs.sv
// Channel equalizer configuration bank with sequential byte access
`timescale 1ns/1ps
`default_nettype none
`include "eqc_defines.svh"

module eqc_config_regs
    import eqc_pkg::*;
#(
    parameter int NCH = 8
) (
    input  wire logic           clk_sys_i,
    input  wire logic           rst_i,
    input  wire logic           xfer_start_i,
    input  wire logic           xfer_stop_i,
    input  wire logic           wr_valid_i,
    input  wire logic [7:0]     wr_data_i,
    input  wire logic           rd_req_i,
    output logic      [7:0]     rd_data_o,
    output logic                rd_valid_o,
    output logic                xfer_open_o,
    output logic      [7:0]     byte_index_o,
    output logic      [NCH*4-1:0] eq_code_o,
    output logic      [NCH*2-1:0] flat_gain_o,
    output logic      [NCH-1:0] swing_o,
    output logic      [NCH-1:0] det_pd_o
);

    localparam int HALF = NCH / 2;

    eqc_acc_state_t state_reg;
    eqc_acc_state_t state_next;
    logic [7:0]     idx_reg;
    logic [7:0]     idx_next;
    logic [7:0]     pd_reg;
    logic [7:0]     pd_next;
    logic [7:0]     rd_data_reg;
    logic [7:0]     rd_data_next;
    logic           rd_valid_reg;
    logic           rd_valid_next;
    logic           wr_take;
    logic           rd_take;
    logic [7:0]     rd_byte;
    logic [2:0]     chan_sel;
    logic [7:0]     cfg_byte [NCH];
    logic [NCH-1:0] cfg_wr_en;

    // ======================================================================
    // Access qualification
    // A new start abandons whatever came with it; write beats read so a
    // byte is never both stored and fetched at one index.
    assign wr_take = (state_reg == EQC_ACC_OPEN) && wr_valid_i
                     && !xfer_start_i;
    assign rd_take = (state_reg == EQC_ACC_OPEN) && rd_req_i
                     && !wr_valid_i && !xfer_start_i;
    assign chan_sel = 3'(idx_reg - `EQC_CHAN_FIRST_IDX);

    // ======================================================================
    // Channel bytes
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_chan
            assign cfg_wr_en[c] = wr_take
                && (idx_reg == 8'(`EQC_CHAN_FIRST_IDX + c));

            eqc_cfg_byte u_byte (
                .clk_sys_i   (clk_sys_i),
                .rst_i       (rst_i),
                .wr_en_i     (cfg_wr_en[c]),
                .wr_data_i   (wr_data_i),
                .byte_o      (cfg_byte[c]),
                .eq_code_o   (eq_code_o[c*4 +: 4]),
                .flat_gain_o (flat_gain_o[c*2 +: 2]),
                .swing_o     (swing_o[c])
            );

            // Group A sits in the upper nibble, group B in the lower
            if (c < HALF) begin : g_pd_a
                assign det_pd_o[c] = pd_reg[`EQC_PD_GRP_A_LSB + c];
            end else begin : g_pd_b
                assign det_pd_o[c] = pd_reg[c - HALF];
            end

            // Each channel byte reaches its own field outputs and reads back
            chan_fields_a: assert property (@(posedge clk_sys_i)
                disable iff (rst_i)
                cfg_wr_en[c] |=> eq_code_o[c*4 +: 4] == $past(wr_data_i[7:4])
                    && flat_gain_o[c*2 +: 2] == $past(wr_data_i[3:2])
                    && swing_o[c] == $past(wr_data_i[0]))
                else $error("channel fields do not follow the written byte");

            chan_readback_a: assert property (@(posedge clk_sys_i)
                disable iff (rst_i)
                rd_take && idx_reg == 8'(`EQC_CHAN_FIRST_IDX + c)
                |=> rd_data_o == $past(cfg_byte[c]))
                else $error("channel byte did not read back at its index");
        end
    endgenerate

    // ======================================================================
    // Read mux
    always_comb begin
        rd_byte = `EQC_RD_UNMAPPED;
        if (idx_reg == `EQC_PD_IDX) begin
            rd_byte = pd_reg;
        end else if (idx_reg >= `EQC_CHAN_FIRST_IDX
                     && idx_reg <= `EQC_CHAN_LAST_IDX) begin
            rd_byte = cfg_byte[chan_sel];
        end else begin
            rd_byte = `EQC_RD_UNMAPPED;
        end
    end

    // ======================================================================
    // Access sequencer
    // Index saturates instead of wrapping so a runaway burst cannot loop
    // back and overwrite the channel bytes.
    always_comb begin
        state_next    = state_reg;
        idx_next      = idx_reg;
        rd_data_next  = rd_data_reg;
        rd_valid_next = 1'b0;
        case (state_reg)
            EQC_ACC_IDLE: begin
                if (xfer_start_i) begin
                    state_next = EQC_ACC_OPEN;
                    idx_next   = 8'h00;
                end
            end
            EQC_ACC_OPEN: begin
                if (xfer_start_i) begin
                    idx_next = 8'h00;
                end else begin
                    if ((wr_take || rd_take) && idx_reg != `EQC_IDX_MAX) begin
                        idx_next = idx_reg + 8'h01;
                    end
                    if (rd_take) begin
                        rd_data_next  = rd_byte;
                        rd_valid_next = 1'b1;
                    end
                    // A byte taken with the stop still completes
                    if (xfer_stop_i) begin
                        state_next = EQC_ACC_IDLE;
                    end
                end
            end
            default: begin
                state_next = EQC_ACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_reg    <= EQC_ACC_IDLE;
            idx_reg      <= 8'h00;
            rd_data_reg  <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            idx_reg      <= idx_next;
            rd_data_reg  <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    // ======================================================================
    // Detector power-down byte
    always_comb begin
        pd_next = pd_reg;
        if (wr_take && idx_reg == `EQC_PD_IDX) begin
            pd_next = wr_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pd_reg <= `EQC_PD_RESET;
        end else begin
            pd_reg <= pd_next;
        end
    end

    assign rd_data_o    = rd_data_reg;
    assign rd_valid_o   = rd_valid_reg;
    assign xfer_open_o  = state_reg[1];
    assign byte_index_o = idx_reg;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence wr_at(logic [7:0] i);
        wr_take && idx_reg == i;
    endsequence

    sequence quiet_two;
        !wr_take ##1 !wr_take;
    endsequence

    a0_eq_map_a: assert property (
        wr_at(8'h03) |=> eq_code_o[3:0] == $past(wr_data_i[7:4]))
        else $error("A0 equalizer code not taken from bits 7..4");

    b0_fg_map_a: assert property (
        wr_at(8'h07) |=> flat_gain_o[9:8] == $past(wr_data_i[3:2]))
        else $error("B0 flat gain not taken from bits 3..2");

    b3_swing_a: assert property (
        wr_at(8'h0A) |=> swing_o[7] == $past(wr_data_i[0])
                         && eq_code_o[31:28] == $past(wr_data_i[7:4]))
        else $error("B3 swing or equalizer mismatch");

    chan_read_a: assert property (
        rd_take && idx_reg == 8'h04 |=> rd_valid_o
            && rd_data_o == $past(cfg_byte[1]))
        else $error("read at index 4 did not return channel A1 byte");

    reset_zero_a: assert property (@(posedge clk_sys_i)
        disable iff (1'b0)
        rst_i |=> det_pd_o == '0 && eq_code_o == '0
                  && flat_gain_o == '0 && swing_o == '0)
        else $error("config not cleared by reset");

    pd_map_a: assert property (
        wr_at(8'h0B) |=> det_pd_o[0] == $past(wr_data_i[4])
                         && det_pd_o[7] == $past(wr_data_i[3]))
        else $error("detector power-down bit mapping wrong");

    fg_zero_db_a: assert property (
        wr_at(8'h05) ##0 wr_data_i[3:2] == EQC_FG_0DB
        |=> flat_gain_o[5:4] == EQC_FG_0DB)
        else $error("A2 flat gain code for 0 dB not held");

    swing_hi_a: assert property (
        wr_at(8'h06) ##0 wr_data_i[0] == EQC_SW_1000MV
        |=> swing_o[3] == EQC_SW_1000MV ##1 swing_o[3] == EQC_SW_1000MV
            || wr_take)
        else $error("A3 swing select for 1000 mV not held");

    hold_fields_a: assert property (
        quiet_two |-> $stable(eq_code_o) && $stable(flat_gain_o)
                      && $stable(swing_o) && $stable(det_pd_o))
        else $error("channel controls moved without a write");

    idx_step_a: assert property (
        (wr_take || rd_take) && idx_reg != 8'hFF && !xfer_start_i
        |=> idx_reg == $past(idx_reg) + 8'h01)
        else $error("byte index did not advance by one");

    sequence start_taken;
        xfer_start_i;
    endsequence

    sequence stop_taken;
        state_reg == EQC_ACC_OPEN && xfer_stop_i && !xfer_start_i;
    endsequence

    sequence idle_wait;
        state_reg == EQC_ACC_IDLE && !xfer_start_i;
    endsequence

    restart_idx_a: assert property (
        start_taken |=> xfer_open_o && byte_index_o == 8'h00)
        else $error("start did not open access at byte zero");

    stop_close_a: assert property (
        stop_taken |=> !xfer_open_o)
        else $error("stop did not close the access");

    // Requests while idle must leave index, fields and read data alone
    idle_hold_a: assert property (
        idle_wait |=> !rd_valid_o && $stable(byte_index_o)
                      && $stable(eq_code_o) && $stable(det_pd_o))
        else $error("idle request changed the bank");

    unmapped_wr_a: assert property (
        wr_take && (idx_reg < `EQC_CHAN_FIRST_IDX || idx_reg > `EQC_PD_IDX)
        |=> $stable(eq_code_o) && $stable(flat_gain_o)
            && $stable(swing_o) && $stable(det_pd_o))
        else $error("write outside bytes 3..11 changed a control");

    unmapped_rd_a: assert property (
        rd_take && (idx_reg < `EQC_CHAN_FIRST_IDX || idx_reg > `EQC_PD_IDX)
        |=> rd_valid_o && rd_data_o == `EQC_RD_UNMAPPED)
        else $error("read outside bytes 3..11 not answered with zero");

    pd_all_a: assert property (
        wr_at(`EQC_PD_IDX) |=> det_pd_o[3:0] == $past(wr_data_i[7:4])
                              && det_pd_o[7:4] == $past(wr_data_i[3:0]))
        else $error("detector power-down byte not mapped to all channels");

    pd_readback_a: assert property (
        rd_take && idx_reg == `EQC_PD_IDX |=> rd_data_o == $past(pd_reg))
        else $error("power-down byte did not read back");

    rd_quiet_a: assert property (
        !rd_take |=> !rd_valid_o)
        else $error("read answer without a read");

    wr_rd_drop_a: assert property (
        wr_take && rd_req_i |=> !rd_valid_o && $stable(rd_data_o))
        else $error("read beside a write was not dropped");

endmodule : eqc_config_regs

`default_nettype wire

// ### eqc_ctl_model.sv
// Controller model that walks the config bank bytes from index zero
`timescale 1ns/1ps
`default_nettype none

module eqc_ctl_model (
    input  wire logic       clk_sys_i,
    input  wire logic       rd_valid_i,
    input  wire logic [7:0] rd_data_i,
    output logic            xfer_start_o,
    output logic            xfer_stop_o,
    output logic            wr_valid_o,
    output logic      [7:0] wr_data_o,
    output logic            rd_req_o
);
    logic [7:0] rd_q [$];

    initial begin
        xfer_start_o = 1'b0;
        xfer_stop_o  = 1'b0;
        wr_valid_o   = 1'b0;
        wr_data_o    = 8'hA5;
        rd_req_o     = 1'b0;
    end

    // ======================================================================
    // Read answers are captured on the edge that sees the one-cycle pulse
    always @(posedge clk_sys_i) begin
        if (rd_valid_i === 1'b1) begin
            rd_q.push_back(rd_data_i);
        end
    end

    // ======================================================================
    // One clock of requests; unqualified data toggles so no stale byte hides
    task automatic cyc(input logic st, sp, wv, rq, input logic [7:0] d);
        @(posedge clk_sys_i);
        xfer_start_o <= st;
        xfer_stop_o  <= sp;
        wr_valid_o   <= wv;
        rd_req_o     <= rq;
        wr_data_o    <= wv ? d : ~wr_data_o;
    endtask : cyc

    // Bytes go strictly upward from index zero; gaps model a slow controller
    task automatic xfer(input logic wr, input int n,
                        input logic [7:0] d [0:15], input logic gap);
        rd_q.delete();
        cyc(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
        for (int i = 0; i < n; i++) begin
            cyc(1'b0, 1'b0, wr, !wr, d[i]);
            if (gap) begin
                cyc(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
            end
        end
        cyc(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        #1;
    endtask : xfer

    // Stop after a complete byte
    task automatic close();
        cyc(1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
        cyc(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        #1;
    endtask : close
endmodule : eqc_ctl_model
`default_nettype wire

// ### eqc_config_regs_tb.sv
// Self-checking bench for the channel config bank
`timescale 1ns/1ps
`default_nettype none

module eqc_config_regs_tb;
    logic              clk_sys_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              st, sp, wv, rq, rdv, opn;
    logic        [7:0] wd, rdd, idx, pd;
    logic       [31:0] eq;
    logic       [15:0] fg;
    logic        [7:0] sw;
    logic        [7:0] img [0:15];
    logic        [7:0] d   [0:15];
    int                n_errors = 0;
    int                check_count = 0;
    integer            seed = 32'h7614;

    always #2.5 clk_sys_i = ~clk_sys_i;

    eqc_config_regs #(.NCH(8)) dut_u (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .xfer_start_i(st),
        .xfer_stop_i(sp), .wr_valid_i(wv), .wr_data_i(wd), .rd_req_i(rq),
        .rd_data_o(rdd), .rd_valid_o(rdv), .xfer_open_o(opn),
        .byte_index_o(idx), .eq_code_o(eq), .flat_gain_o(fg),
        .swing_o(sw), .det_pd_o(pd));

    eqc_ctl_model ctl_u (
        .clk_sys_i(clk_sys_i), .rd_valid_i(rdv), .rd_data_i(rdd),
        .xfer_start_o(st), .xfer_stop_o(sp), .wr_valid_o(wv),
        .wr_data_o(wd), .rd_req_o(rq));

    // ======================================================================
    // Checking helpers
    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Field image the analog paths should see, from the byte image
    function automatic logic [31:0] fld(input int k);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int c = 0; c < 8; c++) begin
            case (k)
                0: r[c*4+:4] = img[3+c][7:4];
                1: r[c*2+:2] = img[3+c][3:2];
                default: r[c] = img[3+c][0];
            endcase
        end
        if (k == 3) begin
            r = {24'h00_0000, img[11][3:0], img[11][7:4]};
        end
        return r;
    endfunction : fld

    task automatic chk_fields();
        chk(eq, fld(0));
        chk({16'h0000, fg}, fld(1));
        chk({24'h00_0000, sw}, fld(2));
        chk({24'h00_0000, pd}, fld(3));
    endtask : chk_fields

    task automatic wr_pass(input int n, input logic gap);
        for (int i = 3; i < 12 && i < n; i++) begin
            img[i] = d[i];
        end
        ctl_u.xfer(1'b1, n, d, gap);
        chk({24'h00_0000, idx}, n);
        chk({31'h0, opn}, 1);
        ctl_u.close();
        chk({31'h0, opn}, 0);
        chk_fields();
    endtask : wr_pass

    // Bytes outside 3..11 read back as zero
    task automatic rd_pass(input int n, input logic gap);
        ctl_u.xfer(1'b0, n, d, gap);
        ctl_u.close();
        chk(ctl_u.rd_q.size(), n);
        for (int i = 0; i < n && i < ctl_u.rd_q.size(); i++) begin
            chk(ctl_u.rd_q[i], (i >= 3 && i <= 11) ? img[i] : 8'h00);
        end
    endtask : rd_pass

    task automatic give_verdict();
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // ======================================================================
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        n_errors++;
        $display("ERROR %0t: run did not finish", $time);
        give_verdict();
    end

    initial begin
        for (int i = 0; i < 16; i++) begin
            img[i] = 8'h00;
            d[i]   = 8'hFF;
        end
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk_fields();
        // Every flat-gain code and both swings, reserved bit set
        for (int c = 0; c < 8; c++) begin
            d[3+c] = {c[3:0], c[1:0], 1'b1, c[0]};
        end
        wr_pass(12, 1'b0);
        rd_pass(13, 1'b0);
        repeat (20) begin
            for (int i = 0; i < 16; i++) begin
                d[i] = $random(seed);
            end
            wr_pass(4 + ($unsigned($random(seed)) % 11),
                    $random(seed) & 1);
            rd_pass(12, $random(seed) & 1);
        end
        // Refused requests: bytes while idle, a byte beside a restart, reads
        // beside writes; the last byte then comes together with the stop
        ctl_u.rd_q.delete();
        ctl_u.cyc(1'b0, 1'b0, 1'b1, 1'b0, 8'hFF);
        ctl_u.cyc(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
        ctl_u.cyc(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
        repeat (3) ctl_u.cyc(1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
        ctl_u.cyc(1'b1, 1'b0, 1'b1, 1'b0, 8'hFF);
        repeat (3) ctl_u.cyc(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        ctl_u.cyc(1'b0, 1'b1, 1'b1, 1'b0, 8'h5A);
        ctl_u.cyc(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        #1;
        img[3] = 8'h5A;
        chk({24'h00_0000, idx}, 4);
        chk({31'h0, opn}, 0);
        chk(ctl_u.rd_q.size(), 0);
        chk_fields();
        // Reset in mid-run clears every byte
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            img[i] = 8'h00;
        end
        @(posedge clk_sys_i);
        #1;
        chk_fields();
        rd_pass(12, 1'b0);
        give_verdict();
    end
endmodule : eqc_config_regs_tb
`default_nettype wire
